// File: flow_char_bank.sv
// small byte store holding the software flow-control characters
`timescale 1ns/10ps
module flow_char_bank
  #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
  )
  (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           wr_en,
  input  wire logic [$clog2(DEPTH)-1:0]       wr_idx,
  input  wire logic [WIDTH-1:0]               wr_data,
  output logic      [DEPTH-1:0][WIDTH-1:0]    entries_q
  );

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          entries_q[i] <= '0;
        end
        else if (wr_en && (wr_idx == ($clog2(DEPTH))'(i)))
        begin
          entries_q[i] <= wr_data;
        end
      end
    end
  endgenerate

endmodule

// File: host_model.sv
// host side model issuing single register accesses
`timescale 1ns/10ps
module host_model
  (
  input  wire logic             core_clk,
  output regmap_pkg::reg_offset_t reg_addr,
  output logic                  reg_wr,
  output logic                  reg_rd,
  output logic [7:0]            reg_wdata
  );
  import regmap_pkg::*;
  initial
  begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // request held through the taking edge, data line scrambled when idle
  task automatic access(input logic w, input reg_offset_t a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = w ? v : ~reg_wdata;
    reg_wr = w;
    reg_rd = !w;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
endmodule

// File: regmap_monitor.sv
// concurrent checks on the register port of the uart channel register map
`timescale 1ns/10ps
module regmap_monitor
  import regmap_pkg::*;
  (
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire regmap_pkg::reg_offset_t  reg_addr,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_wdata,
  input wire logic [7:0]               reg_rdata_q,
  input wire regmap_pkg::chan_status_t status,
  input wire regmap_pkg::chan_config_t config_q,
  input wire logic [7:0]               tx_data_q,
  input wire logic                     tx_push_q,
  input wire logic                     rx_pop_q,
  input wire logic                     tx_fifo_reset_q,
  input wire logic                     rx_fifo_reset_q
  );
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // config_q lags a write by one edge, so only isolated requests are judged
  chk_tx_push: assert property (
    reg_wr && !$past(reg_wr) && reg_addr == OFF_HOLDING && !config_q.line_setup.div_access
    |=> tx_push_q && tx_data_q == $past(reg_wdata)) else $error("holding write gave no push");
  chk_no_push_div: assert property (
    reg_wr && !$past(reg_wr) && reg_addr == OFF_HOLDING && config_q.line_setup.div_access
    |=> !tx_push_q) else $error("divisor write pushed a byte");
  chk_pop_read: assert property (
    reg_rd && !$past(reg_wr) && reg_addr == OFF_HOLDING && !config_q.line_setup.div_access
    |=> rx_pop_q) else $error("holding read gave no pop");
  chk_pop_cause: assert property (
    rx_pop_q |-> $past(reg_rd) && $past(reg_addr) == OFF_HOLDING) else $error("pop without holding read");
  chk_fifo_reset: assert property (
    reg_wr && !$past(reg_wr) && reg_addr == OFF_INT_FIFO && !config_q.line_setup.div_access
    |=> tx_fifo_reset_q == $past(reg_wdata[2]) && rx_fifo_reset_q == $past(reg_wdata[1]))
    else $error("fifo reset pulses wrong");
  chk_rx_fill: assert property (
    reg_rd && reg_addr == OFF_RX_FILL |=> reg_rdata_q == {1'b0, $past(status.rx_fill)})
    else $error("rx fill read wrong");
  chk_line_cond: assert property (
    reg_rd && !$past(reg_wr) && reg_addr == OFF_LINE_COND && config_q.line_setup != ENHANCED_PAGE_KEY
    |=> reg_rdata_q == $past(status.line_flags))
    else $error("line condition read wrong");
  chk_reserved_zero: assert property (
    reg_rd && reg_addr == OFF_RESERVED |=> reg_rdata_q == 8'h00) else $error("reserved read not zero");
  cover property (tx_push_q);
  cover property (rx_pop_q);
  cover property (tx_fifo_reset_q);
endmodule
bind uart_channel_register_map regmap_monitor u_mon (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .status(status),
  .config_q(config_q), .tx_data_q(tx_data_q), .tx_push_q(tx_push_q), .rx_pop_q(rx_pop_q),
  .tx_fifo_reset_q(tx_fifo_reset_q), .rx_fifo_reset_q(rx_fifo_reset_q));

// File: regmap_pkg.sv
// constants, field layouts and carrier types for the uart channel register map
package regmap_pkg;

  typedef logic [3:0] reg_offset_t;

  localparam reg_offset_t OFF_HOLDING    = 4'h0;
  localparam reg_offset_t OFF_INT_MASK   = 4'h1;
  localparam reg_offset_t OFF_INT_FIFO   = 4'h2;
  localparam reg_offset_t OFF_LINE_SETUP = 4'h3;
  localparam reg_offset_t OFF_MODEM_CTRL = 4'h4;
  localparam reg_offset_t OFF_LINE_COND  = 4'h5;
  localparam reg_offset_t OFF_MODEM_COND = 4'h6;
  localparam reg_offset_t OFF_SCRATCH    = 4'h7;
  localparam reg_offset_t OFF_TX_FILL    = 4'h8;
  localparam reg_offset_t OFF_RX_FILL    = 4'h9;
  localparam reg_offset_t OFF_GPIO_DIR   = 4'ha;
  localparam reg_offset_t OFF_GPIO_STATE = 4'hb;
  localparam reg_offset_t OFF_GPIO_INT   = 4'hc;
  localparam reg_offset_t OFF_RESERVED   = 4'hd;
  localparam reg_offset_t OFF_GPIO_SETUP = 4'he;
  localparam reg_offset_t OFF_EXTRA      = 4'hf;

  // line_setup value that opens the enhanced register page
  localparam logic [7:0] ENHANCED_PAGE_KEY = 8'hbf;

  localparam int DIV_ACCESS_BIT = 7;
  localparam int ENHANCED_BIT   = 4;
  localparam int UNLOCK_BIT     = 2;
  localparam int FLOW_CHARS     = 4;

  // bits that only count while enhanced_function bit 4 is set
  localparam logic [7:0] INT_MASK_ENH_BITS  = 8'hf0;
  localparam logic [7:0] FIFO_SETUP_ENH_BITS = 8'h30;
  localparam logic [7:0] MODEM_CTRL_ENH_BITS = 8'he0;
  localparam logic [5:0] INT_SRC_ENH_BITS   = 6'h30;

  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [7:0] RST_LINE_SETUP  = 8'h00;
  localparam logic [7:0] RST_INT_MASK    = 8'h00;
  localparam logic [7:0] RST_FIFO_SETUP  = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL  = 8'h00;
  localparam logic [7:0] RST_ENHANCED    = 8'h00;
  localparam logic [7:0] RST_EXTRA       = 8'h00;
  localparam logic [7:0] RST_GPIO        = 8'h00;
  localparam logic [7:0] RST_DIVISOR     = 8'h00;

  typedef struct packed {
    logic       div_access;
    logic       force_break;
    logic       forced_parity;
    logic       even_parity;
    logic       parity_en;
    logic       stop_bits;
    logic [1:0] word_len;
  } line_setup_t;

  typedef struct packed {
    logic [1:0] rx_trigger;
    logic [1:0] tx_trigger;
    logic       dma_mode;
    logic       tx_reset;
    logic       rx_reset;
    logic       fifo_en;
  } fifo_setup_t;

  typedef struct packed {
    logic prescale_sel;
    logic ir_mode;
    logic any_char_resume;
    logic loopback;
    logic aux_output_two;
    logic unlock;
    logic rts_ctrl;
    logic dtr_ctrl;
  } modem_line_control_t;

  typedef enum logic [4:0] {
    TGT_NONE, TGT_HOLDING, TGT_DIV_LO, TGT_DIV_HI, TGT_INT_MASK, TGT_FRAC,
    TGT_INT_FIFO, TGT_ENHANCED, TGT_LINE_SETUP, TGT_MODEM_CTRL, TGT_LINE_COND,
    TGT_MODEM_COND, TGT_HALT_RESUME, TGT_SCRATCH, TGT_TRIGGER, TGT_FLOW_CHAR,
    TGT_TX_FILL, TGT_RX_FILL, TGT_GPIO_DIR, TGT_GPIO_STATE, TGT_GPIO_INT,
    TGT_RESERVED, TGT_GPIO_SETUP, TGT_EXTRA
  } reg_target_t;

  // state reported by the serial engine of the channel
  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] line_flags;
    logic [5:0] int_code;
    logic [6:0] tx_fill;
    logic [6:0] rx_fill;
  } chan_status_t;

  // effective settings handed to the serial engine
  typedef struct packed {
    line_setup_t                         line_setup;
    logic [7:0]                          int_mask;
    fifo_setup_t                         fifo_setup;
    modem_line_control_t                 modem_ctrl;
    logic [15:0]                         baud_divisor;
    logic [7:0]                          baud_fraction;
    logic [7:0]                          enhanced_function;
    logic [7:0]                          halt_resume;
    logic [7:0]                          trigger_levels;
    logic [7:0]                          extra_features;
    logic [7:0]                          gpio_direction;
    logic [7:0]                          gpio_pin_state;
    logic [7:0]                          gpio_int_mask;
    logic [7:0]                          gpio_setup;
    logic [FLOW_CHARS-1:0][7:0]          flow_chars;
  } chan_config_t;

endpackage

// File: uart_channel_register_map.sv
// register map and overlaid address decode of one uart channel
`timescale 1ns/10ps
module uart_channel_register_map
  (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire regmap_pkg::reg_offset_t reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata_q,
  input  wire regmap_pkg::chan_status_t status,
  input  wire logic                    carrier_detect_input_n,
  input  wire logic                    ring_indicator_input_n,
  input  wire logic                    data_set_ready_n,
  input  wire logic                    clear_to_send_n,
  output regmap_pkg::chan_config_t     config_q,
  output logic      [7:0]              tx_data_q,
  output logic                         tx_push_q,
  output logic                         rx_pop_q,
  output logic                         tx_fifo_reset_q,
  output logic                         rx_fifo_reset_q,
  output logic                         data_terminal_ready_n_q,
  output logic                         request_to_send_n_q,
  output logic                         aux_output_two_n_q
  );

  import regmap_pkg::*;

  line_setup_t         line_setup_q;
  logic [7:0]          int_mask_q;
  fifo_setup_t         fifo_setup_q;
  modem_line_control_t modem_ctrl_q;
  logic [7:0]          div_lo_q;
  logic [7:0]          div_hi_q;
  logic [7:0]          frac_q;
  logic [7:0]          enhanced_q;
  logic [7:0]          halt_resume_q;
  logic [7:0]          trigger_q;
  logic [7:0]          scratch_q;
  logic [7:0]          extra_q;
  logic [7:0]          gpio_dir_q;
  logic [7:0]          gpio_state_q;
  logic [7:0]          gpio_int_q;
  logic [7:0]          gpio_setup_q;
  logic [3:0]          modem_meta_q;
  logic [3:0]          modem_sync_q;
  logic [3:0]          modem_prev_q;
  logic [3:0]          modem_delta_q;
  logic [FLOW_CHARS-1:0][7:0] flow_chars;

  reg_target_t         tgt;
  logic                enh_on;
  logic                page_key;
  logic                unlock_on;
  logic [7:0]          int_mask_eff;
  logic [7:0]          fifo_setup_eff;
  logic [7:0]          modem_ctrl_eff;
  logic [5:0]          int_code_eff;
  logic [7:0]          rdata_d;
  logic                wr_flow;
  logic [1:0]          flow_idx;

  assign page_key  = (line_setup_q == ENHANCED_PAGE_KEY);
  assign enh_on    = enhanced_q[ENHANCED_BIT];
  assign unlock_on = modem_ctrl_q.unlock;

  // enhanced fields behave as zero until enabled
  assign int_mask_eff   = enh_on ? int_mask_q : (int_mask_q & ~INT_MASK_ENH_BITS);
  assign fifo_setup_eff = enh_on ? fifo_setup_q : (fifo_setup_q & ~FIFO_SETUP_ENH_BITS);
  assign modem_ctrl_eff = enh_on ? modem_ctrl_q : (modem_ctrl_q & ~MODEM_CTRL_ENH_BITS);
  assign int_code_eff   = enh_on ? status.int_code : (status.int_code & ~INT_SRC_ENH_BITS);

  // pick which overlaid register the offset reaches
  always_comb
  begin
    tgt = TGT_NONE;
    case (reg_addr)
      OFF_HOLDING:
      begin
        tgt = line_setup_q.div_access ? TGT_DIV_LO : TGT_HOLDING;
      end
      OFF_INT_MASK:
      begin
        tgt = line_setup_q.div_access ? TGT_DIV_HI : TGT_INT_MASK;
      end
      OFF_INT_FIFO:
      begin
        if (page_key)
        begin
          tgt = TGT_ENHANCED;
        end
        else if (line_setup_q.div_access && enh_on)
        begin
          tgt = TGT_FRAC;
        end
        else
        begin
          tgt = TGT_INT_FIFO;
        end
      end
      OFF_LINE_SETUP:
      begin
        tgt = TGT_LINE_SETUP;
      end
      OFF_MODEM_CTRL:
      begin
        tgt = page_key ? TGT_FLOW_CHAR : TGT_MODEM_CTRL;
      end
      OFF_LINE_COND:
      begin
        tgt = page_key ? TGT_FLOW_CHAR : TGT_LINE_COND;
      end
      OFF_MODEM_COND:
      begin
        if (page_key)
        begin
          tgt = TGT_FLOW_CHAR;
        end
        else
        begin
          tgt = unlock_on ? TGT_HALT_RESUME : TGT_MODEM_COND;
        end
      end
      OFF_SCRATCH:
      begin
        if (page_key)
        begin
          tgt = TGT_FLOW_CHAR;
        end
        else
        begin
          tgt = unlock_on ? TGT_TRIGGER : TGT_SCRATCH;
        end
      end
      OFF_TX_FILL:    tgt = TGT_TX_FILL;
      OFF_RX_FILL:    tgt = TGT_RX_FILL;
      OFF_GPIO_DIR:   tgt = TGT_GPIO_DIR;
      OFF_GPIO_STATE: tgt = TGT_GPIO_STATE;
      OFF_GPIO_INT:   tgt = TGT_GPIO_INT;
      OFF_RESERVED:   tgt = TGT_RESERVED;
      OFF_GPIO_SETUP: tgt = TGT_GPIO_SETUP;
      OFF_EXTRA:      tgt = TGT_EXTRA;
      default:        tgt = TGT_NONE;
    endcase
  end

  // read data selection
  always_comb
  begin
    rdata_d = 8'h00;
    case (tgt)
      TGT_HOLDING:     rdata_d = status.rx_byte;
      TGT_DIV_LO:      rdata_d = div_lo_q;
      TGT_DIV_HI:      rdata_d = div_hi_q;
      TGT_INT_MASK:    rdata_d = int_mask_eff;
      TGT_FRAC:        rdata_d = frac_q;
      TGT_INT_FIFO:    rdata_d = {{2{fifo_setup_q.fifo_en}}, int_code_eff};
      TGT_ENHANCED:    rdata_d = enhanced_q;
      TGT_LINE_SETUP:  rdata_d = line_setup_q;
      TGT_MODEM_CTRL:  rdata_d = modem_ctrl_eff;
      TGT_LINE_COND:   rdata_d = status.line_flags;
      TGT_MODEM_COND:  rdata_d = {modem_sync_q, modem_delta_q};
      TGT_HALT_RESUME: rdata_d = halt_resume_q;
      TGT_SCRATCH:     rdata_d = scratch_q;
      TGT_TRIGGER:     rdata_d = trigger_q;
      TGT_FLOW_CHAR:   rdata_d = flow_chars[flow_idx];
      TGT_TX_FILL:     rdata_d = {1'b0, status.tx_fill};
      TGT_RX_FILL:     rdata_d = {1'b0, status.rx_fill};
      TGT_GPIO_DIR:    rdata_d = gpio_dir_q;
      TGT_GPIO_STATE:  rdata_d = gpio_state_q;
      TGT_GPIO_INT:    rdata_d = gpio_int_q;
      TGT_RESERVED:    rdata_d = 8'h00;
      TGT_GPIO_SETUP:  rdata_d = gpio_setup_q;
      TGT_EXTRA:       rdata_d = extra_q;
      default:         rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_q <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= rdata_d;
    end
  end

  // holding register traffic toward the serial engine
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_data_q <= RST_BYTE;
      tx_push_q <= 1'b0;
      rx_pop_q  <= 1'b0;
    end
    else
    begin
      tx_push_q <= reg_wr && (tgt == TGT_HOLDING);
      rx_pop_q  <= reg_rd && (tgt == TGT_HOLDING);
      if (reg_wr && (tgt == TGT_HOLDING))
      begin
        tx_data_q <= reg_wdata;
      end
    end
  end

  // baud divisor bytes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_lo_q <= RST_DIVISOR;
      div_hi_q <= RST_DIVISOR;
      frac_q   <= RST_DIVISOR;
    end
    else if (reg_wr)
    begin
      if (tgt == TGT_DIV_LO)
      begin
        div_lo_q <= reg_wdata;
      end
      if (tgt == TGT_DIV_HI)
      begin
        div_hi_q <= reg_wdata;
      end
      if (tgt == TGT_FRAC)
      begin
        frac_q <= reg_wdata;
      end
    end
  end

  // line, interrupt, modem and enhanced control
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      line_setup_q <= RST_LINE_SETUP;
      int_mask_q   <= RST_INT_MASK;
      modem_ctrl_q <= RST_MODEM_CTRL;
      enhanced_q   <= RST_ENHANCED;
    end
    else if (reg_wr)
    begin
      case (tgt)
        TGT_LINE_SETUP: line_setup_q <= reg_wdata;
        TGT_INT_MASK:   int_mask_q   <= reg_wdata;
        TGT_MODEM_CTRL: modem_ctrl_q <= reg_wdata;
        TGT_ENHANCED:   enhanced_q   <= reg_wdata;
        default:        line_setup_q <= line_setup_q;
      endcase
    end
  end

  // fifo_setup is write-only; its reset bits become one-cycle pulses
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_setup_q    <= RST_FIFO_SETUP;
      tx_fifo_reset_q <= 1'b0;
      rx_fifo_reset_q <= 1'b0;
    end
    else if (reg_wr && (tgt == TGT_INT_FIFO))
    begin
      fifo_setup_q    <= reg_wdata;
      tx_fifo_reset_q <= reg_wdata[2];
      rx_fifo_reset_q <= reg_wdata[1];
    end
    else
    begin
      tx_fifo_reset_q <= 1'b0;
      rx_fifo_reset_q <= 1'b0;
    end
  end

  // flow thresholds, trigger levels, scratch
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      halt_resume_q <= RST_BYTE;
      trigger_q     <= RST_BYTE;
      scratch_q     <= RST_BYTE;
    end
    else if (reg_wr)
    begin
      case (tgt)
        TGT_HALT_RESUME: halt_resume_q <= reg_wdata;
        TGT_TRIGGER:     trigger_q     <= reg_wdata;
        TGT_SCRATCH:     scratch_q     <= reg_wdata;
        default:         scratch_q     <= scratch_q;
      endcase
    end
  end

  // gpio and extra feature bytes; reserved and fill offsets ignore writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      gpio_dir_q   <= RST_GPIO;
      gpio_state_q <= RST_GPIO;
      gpio_int_q   <= RST_GPIO;
      gpio_setup_q <= RST_GPIO;
      extra_q      <= RST_EXTRA;
    end
    else if (reg_wr)
    begin
      case (tgt)
        TGT_GPIO_DIR:   gpio_dir_q   <= reg_wdata;
        TGT_GPIO_STATE: gpio_state_q <= reg_wdata;
        TGT_GPIO_INT:   gpio_int_q   <= reg_wdata;
        TGT_GPIO_SETUP: gpio_setup_q <= reg_wdata;
        TGT_EXTRA:      extra_q      <= reg_wdata;
        default:        extra_q      <= extra_q;
      endcase
    end
  end

  // resume and stop characters live in the byte bank
  assign wr_flow  = reg_wr && (tgt == TGT_FLOW_CHAR);
  assign flow_idx = reg_addr[1:0];

  flow_char_bank
    #(
    .DEPTH (FLOW_CHARS),
    .WIDTH (8)
    )
  u_flow_chars
    (
    .core_clk  (core_clk),
    .rst       (rst),
    .wr_en     (wr_flow),
    .wr_idx    (flow_idx),
    .wr_data   (reg_wdata),
    .entries_q (flow_chars)
    );

  // modem input pins, synchronised before use
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      modem_meta_q <= 4'h0;
      modem_sync_q <= 4'h0;
      modem_prev_q <= 4'h0;
    end
    else
    begin
      modem_meta_q <= ~{carrier_detect_input_n, ring_indicator_input_n, data_set_ready_n, clear_to_send_n};
      modem_sync_q <= modem_meta_q;
      modem_prev_q <= modem_sync_q;
    end
  end

  // change flags: sticky, cleared by reading, a new change wins over the clear
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_delta
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          modem_delta_q[b] <= 1'b0;
        end
        else if (modem_sync_q[b] != modem_prev_q[b])
        begin
          modem_delta_q[b] <= 1'b1;
        end
        else if (reg_rd && (tgt == TGT_MODEM_COND))
        begin
          modem_delta_q[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // effective settings and handshake pins toward the channel
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      config_q                <= '0;
      data_terminal_ready_n_q <= 1'b1;
      request_to_send_n_q     <= 1'b1;
      aux_output_two_n_q      <= 1'b1;
    end
    else
    begin
      config_q.line_setup        <= line_setup_q;
      config_q.int_mask          <= int_mask_eff;
      config_q.fifo_setup        <= fifo_setup_eff;
      config_q.modem_ctrl        <= modem_ctrl_eff;
      config_q.baud_divisor      <= {div_hi_q, div_lo_q};
      config_q.baud_fraction     <= frac_q;
      config_q.enhanced_function <= enhanced_q;
      config_q.halt_resume       <= halt_resume_q;
      config_q.trigger_levels    <= trigger_q;
      config_q.extra_features    <= extra_q;
      config_q.gpio_direction    <= gpio_dir_q;
      config_q.gpio_pin_state    <= gpio_state_q;
      config_q.gpio_int_mask     <= gpio_int_q;
      config_q.gpio_setup        <= gpio_setup_q;
      config_q.flow_chars        <= flow_chars;
      data_terminal_ready_n_q    <= ~modem_ctrl_q.dtr_ctrl;
      request_to_send_n_q        <= ~modem_ctrl_q.rts_ctrl;
      aux_output_two_n_q         <= ~modem_ctrl_q.aux_output_two;
    end
  end

endmodule

// File: uart_channel_register_map_tb_top.sv
// self-checking bench for the uart channel register map
`timescale 1ns/10ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %s exp=%h got=%h", nm, e, a); end end
module uart_channel_register_map_tb_top;
  import regmap_pkg::*;
  logic         core_clk, rst, reg_wr, reg_rd, rd_pend;
  logic         cd_n, ri_n, dsr_n, cts_n, push, pop, txr, rxr, dtr_n, rts_n, aux_n;
  reg_offset_t  reg_addr;
  logic [7:0]   reg_wdata, reg_rdata_q, tx_data_q, d, lo, hi, sp, ev;
  logic [63:0]  r64;
  chan_status_t status;
  chan_config_t config_q;
  logic [7:0]   exp_q[$];
  int           error_cnt, cmp_count, seed;
  reg_offset_t  rw_offs[6] = '{OFF_SCRATCH, OFF_GPIO_DIR, OFF_GPIO_STATE, OFF_GPIO_INT, OFF_GPIO_SETUP, OFF_EXTRA};

  host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  uart_channel_register_map dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .status(status),
    .carrier_detect_input_n(cd_n), .ring_indicator_input_n(ri_n), .data_set_ready_n(dsr_n),
    .clear_to_send_n(cts_n), .config_q(config_q), .tx_data_q(tx_data_q), .tx_push_q(push), .rx_pop_q(pop),
    .tx_fifo_reset_q(txr), .rx_fifo_reset_q(rxr), .data_terminal_ready_n_q(dtr_n),
    .request_to_send_n_q(rts_n), .aux_output_two_n_q(aux_n));

  task automatic wr(input reg_offset_t a, input logic [7:0] v);
    host.access(1'b1, a, v);
  endtask
  task automatic rd(input reg_offset_t a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // read results land on the taking edge and are checked at the falling edge after it
  always @(posedge core_clk) rd_pend <= reg_rd;
  always @(negedge core_clk)
    if (rd_pend === 1'b1)
    begin
      ev = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK("reg_rdata_q", ev, reg_rdata_q)
    end
  initial
  begin
    #100000;
    error_cnt++;
    $display("[FAIL] watchdog expired");
    stop_test();
  end

  initial
  begin
    seed = 34272;
    rst = 1'b1;
    rd_pend = 1'b0;
    {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
    r64 = {$random(seed), $random(seed)};
    status = r64[36:0];
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (rw_offs[i]) rd(rw_offs[i], 8'h00);
    rd(OFF_INT_FIFO, {2'b00, status.int_code & 6'h0f});
    rd(OFF_TX_FILL, {1'b0, status.tx_fill});
    rd(OFF_RX_FILL, {1'b0, status.rx_fill});
    rd(OFF_MODEM_COND, 8'h00);
    $display("test reset done");
    foreach (rw_offs[i])
    begin
      d = $random(seed);
      wr(rw_offs[i], d);
      rd(rw_offs[i], d);
      if (i == 0) sp = d;
    end
    wr(OFF_INT_MASK, 8'hf5);
    rd(OFF_INT_MASK, 8'h05);
    wr(OFF_RESERVED, 8'hff);
    rd(OFF_RESERVED, 8'h00);
    wr(OFF_LINE_COND, 8'hff);
    rd(OFF_LINE_COND, status.line_flags);
    $display("test storage done");
    wr(OFF_LINE_SETUP, 8'h80);
    lo = $random(seed);
    hi = $random(seed);
    wr(OFF_HOLDING, lo);
    wr(OFF_INT_MASK, hi);
    rd(OFF_HOLDING, lo);
    rd(OFF_INT_MASK, hi);
    rd(OFF_INT_FIFO, {2'b00, status.int_code & 6'h0f});
    rd(OFF_LINE_SETUP, 8'h80);
    `CHK("baud_divisor", {hi, lo}, config_q.baud_divisor)
    $display("test divisor done");
    wr(OFF_LINE_SETUP, 8'hbf);
    wr(OFF_INT_FIFO, 8'h10);
    rd(OFF_INT_FIFO, 8'h10);
    for (int o = 4; o < 8; o++)
    begin
      d = $random(seed);
      wr(reg_offset_t'(o), d);
      rd(reg_offset_t'(o), d);
    end
    wr(OFF_LINE_SETUP, 8'h80);
    d = $random(seed);
    wr(OFF_INT_FIFO, d);
    rd(OFF_INT_FIFO, d);
    wr(OFF_LINE_SETUP, 8'h00);
    wr(OFF_INT_MASK, 8'hf5);
    rd(OFF_INT_MASK, 8'hf5);
    wr(OFF_INT_FIFO, 8'h07);
    rd(OFF_INT_FIFO, {2'b11, status.int_code});
    $display("test enhanced done");
    wr(OFF_MODEM_CTRL, 8'h07);
    rd(OFF_MODEM_CTRL, 8'h07);
    wr(OFF_MODEM_COND, 8'h3c);
    rd(OFF_MODEM_COND, 8'h3c);
    wr(OFF_SCRATCH, 8'hc5);
    rd(OFF_SCRATCH, 8'hc5);
    `CHK("handshake_pins", 3'b001, {dtr_n, rts_n, aux_n})
    wr(OFF_MODEM_CTRL, 8'h00);
    rd(OFF_SCRATCH, sp);
    d = $random(seed);
    wr(OFF_HOLDING, d);
    `CHK("tx_data_q", d, tx_data_q)
    rd(OFF_HOLDING, status.rx_byte);
    $display("test modem control done");
    cts_n = 1'b0;
    repeat (5) @(posedge core_clk);
    rd(OFF_MODEM_COND, 8'h11);
    rd(OFF_MODEM_COND, 8'h10);
    repeat (3) @(posedge core_clk);
    $display("test modem status done");
    stop_test();
  end
endmodule
